/* design/mctu_pkg.sv */
// Constants and types for the six-channel timer with pin roles and events
// What this block does
// [RL1] Input A counts; A-phase on channels 1, 5
// [RL2] Input B counts; B-phase on channels 1, 5
// [RL3] Input C counts; A-phase on channels 2, 4
// [RL4] Input D counts; B-phase on channels 2, 4
// [RL5] Pins A/B: capture, compare output or PWM
// [RL6] Only channels 0, 3 have C/D pins
// [RL7] Channel 0: A-D match/capture plus overflow events
// [RL8] Channel 3: A-D match/capture plus overflow events
// [RL9] Channels 1,2,4,5: A, B, overflow, underflow events
// [RL10] Match/capture events trigger transfer, A events converter; patterns on 0-3
// [RL11] Edge select: rise 00, fall 01, both 1x
// [RL12] Edge ignored: phase mode, undivided, cascade source
package mctu_pkg;

  localparam int NCH = 6;
  localparam int CW  = 16;
  localparam int PW  = 12;

  // Count source select codes
  localparam logic [3:0] SEL_DIV1    = 4'h0;
  localparam logic [3:0] SEL_DIV4    = 4'h1;
  localparam logic [3:0] SEL_DIV16   = 4'h2;
  localparam logic [3:0] SEL_DIV64   = 4'h3;
  localparam logic [3:0] SEL_DIV256  = 4'h4;
  localparam logic [3:0] SEL_DIV1024 = 4'h5;
  localparam logic [3:0] SEL_DIV4096 = 4'h6;
  localparam logic [3:0] SEL_EXT_A   = 4'h7;
  localparam logic [3:0] SEL_EXT_B   = 4'h8;
  localparam logic [3:0] SEL_EXT_C   = 4'h9;
  localparam logic [3:0] SEL_EXT_D   = 4'ha;
  localparam logic [3:0] SEL_CASCADE = 4'hb;

  // Count edge select field
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam int         EDGE_BOTH_BIT = 1;

  // Pin role per general register
  localparam logic [1:0] ROLE_OFF = 2'h0;
  localparam logic [1:0] ROLE_CAP = 2'h1;
  localparam logic [1:0] ROLE_CMP = 2'h2;
  localparam logic [1:0] ROLE_PWM = 2'h3;

  // Values after reset
  localparam logic [CW-1:0] CNT_RESET = 16'h0000;
  localparam logic [CW-1:0] GR_RESET  = 16'hffff;
  localparam logic [PW-1:0] PRE_RESET = 12'h000;

  typedef struct packed {
    logic [3:0]      clk_sel;
    logic [1:0]      count_edge_sel;
    logic            phase_mode;
    logic [3:0][1:0] role;
  } mctu_cfg_t;

  typedef struct packed {
    logic cm_a;
    logic cm_b;
    logic cm_c;
    logic cm_d;
    logic ovf;
    logic udf;
  } mctu_irq_t;

  typedef struct packed {
    logic xfer_req;
    logic conv_start;
    logic pat_a;
    logic pat_b;
  } mctu_trig_t;

endpackage : mctu_pkg

/* design/mctu_chan.sv */
// One timer channel: counter, general registers, pins and events
`timescale 1ns/1ps
module mctu_chan #(
  parameter int CW      = 16,
  parameter bit HAS_CD  = 1'b0,
  parameter bit HAS_UDF = 1'b1,
  parameter bit HAS_PAT = 1'b1
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 up,
  input  wire logic                 dn,
  input  wire logic [3:0][1:0]      role,
  input  wire logic [3:0]           gr_wr_en,
  input  wire logic [CW-1:0]        gr_wr_data,
  input  wire logic [3:0]           pin_in,
  output logic      [CW-1:0]        channel_counter,
  output logic      [3:0]           pin_out,
  output logic      [3:0]           pin_oe,
  output mctu_pkg::mctu_irq_t       irq,
  output mctu_pkg::mctu_trig_t      trig
);

  logic [CW-1:0] general_reg [4];
  logic [3:0]    pin_q;
  logic [3:0]    cap;
  logic [3:0]    cmp;
  logic [3:0]    ev;
  wire  logic [CW-1:0] next_cnt;
  wire  logic          ovf_hit;
  wire  logic          udf_hit;

  assign next_cnt = up ? channel_counter + 16'h0001 :
                    dn ? channel_counter - 16'h0001 : channel_counter;
  assign ovf_hit  = up && (channel_counter == 16'hffff);
  assign udf_hit  = HAS_UDF && dn && (channel_counter == 16'h0000); // [RL9]
  assign ev       = cap | cmp;

  // ****************************************************
  // Per-register capture, compare and pin logic
  // ****************************************************
  for (genvar k = 0; k < 4; k++) begin : g_reg
    localparam bit ACT = (k < 2) || HAS_CD; // [RL6]
    assign cap[k] = ACT && (role[k] == mctu_pkg::ROLE_CAP) &&
                    pin_in[k] && !pin_q[k]; // [RL5]
    assign cmp[k] = ACT && role[k][1] && (up || dn) &&
                    (next_cnt == general_reg[k]); // [RL5]

    // Capture beats a same-cycle write so no event is lost
    always_ff @(posedge clk) begin
      if (reset) begin
        general_reg[k] <= mctu_pkg::GR_RESET;
      end else if (cap[k]) begin
        general_reg[k] <= channel_counter;
      end else if (gr_wr_en[k]) begin
        general_reg[k] <= gr_wr_data;
      end
    end

    always_ff @(posedge clk) begin
      if (reset) begin
        pin_out[k] <= 1'b0;
        pin_oe[k]  <= 1'b0;
      end else begin
        pin_oe[k] <= ACT && role[k][1]; // [RL5] [RL6]
        if (role[k] == mctu_pkg::ROLE_PWM) begin
          pin_out[k] <= ACT && (next_cnt < general_reg[k]); // [RL5]
        end else if (role[k] == mctu_pkg::ROLE_CMP) begin
          pin_out[k] <= pin_out[k] ^ cmp[k]; // [RL5]
        end else begin
          pin_out[k] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      channel_counter <= mctu_pkg::CNT_RESET;
      pin_q           <= 4'h0;
      irq             <= '0;
      trig            <= '0;
    end else begin
      channel_counter <= next_cnt;
      pin_q           <= pin_in;
      irq  <= {ev[0], ev[1], ev[2], ev[3], ovf_hit, udf_hit}; // [RL7] [RL8]
      trig <= {|ev, ev[0], HAS_PAT && ev[0], HAS_PAT && ev[1]}; // [RL10]
    end
  end

endmodule : mctu_chan

/* design/mctu_top.sv */
// Six-channel timer: count sources, edge and phase decoding, channels
`timescale 1ns/1ps
module mctu_top #(
  parameter int NCH = mctu_pkg::NCH,
  parameter int CW  = mctu_pkg::CW
) (
  input  wire logic                              clk,
  input  wire logic                              reset,
  input  wire logic                              ext_count_in_a,
  input  wire logic                              ext_count_in_b,
  input  wire logic                              ext_count_in_c,
  input  wire logic                              ext_count_in_d,
  input  mctu_pkg::mctu_cfg_t [NCH-1:0]          cfg,
  input  wire logic [NCH-1:0][3:0]               gr_wr_en,
  input  wire logic [CW-1:0]                     gr_wr_data,
  input  wire logic [NCH-1:0][3:0]               capcmp_in,
  output logic      [NCH-1:0][CW-1:0]            channel_counter,
  output logic      [NCH-1:0][3:0]               capcmp_out,
  output logic      [NCH-1:0][3:0]               capcmp_oe,
  output mctu_pkg::mctu_irq_t  [NCH-1:0]         irq,
  output mctu_pkg::mctu_trig_t [NCH-1:0]         trig
);

  // ****************************************************
  // Prescaler and input history
  // ****************************************************
  logic [mctu_pkg::PW-1:0] pre;
  logic [mctu_pkg::PW-1:0] pre_q;
  logic [3:0]              ext_q;
  logic [3:0]              ext_qq;

  // Inputs are synchronous, so these are history stages only
  always_ff @(posedge clk) begin
    if (reset) begin
      pre    <= mctu_pkg::PRE_RESET;
      pre_q  <= mctu_pkg::PRE_RESET;
      ext_q  <= 4'h0;
      ext_qq <= 4'h0;
    end else begin
      pre    <= pre + 12'h001;
      pre_q  <= pre;
      ext_q  <= {ext_count_in_d, ext_count_in_c,
                 ext_count_in_b, ext_count_in_a}; // [RL1] [RL2] [RL3] [RL4]
      ext_qq <= ext_q;
    end
  end

  // Level of the selected source; divided clocks are prescaler bits
  function automatic logic src_level(input logic [3:0] sel,
                                     input logic [mctu_pkg::PW-1:0] p,
                                     input logic [3:0] e);
    logic lvl;
    lvl = 1'b0;
    case (sel)
      mctu_pkg::SEL_DIV4:    lvl = p[1];
      mctu_pkg::SEL_DIV16:   lvl = p[3];
      mctu_pkg::SEL_DIV64:   lvl = p[5];
      mctu_pkg::SEL_DIV256:  lvl = p[7];
      mctu_pkg::SEL_DIV1024: lvl = p[9];
      mctu_pkg::SEL_DIV4096: lvl = p[11];
      mctu_pkg::SEL_EXT_A:   lvl = e[0]; // [RL1]
      mctu_pkg::SEL_EXT_B:   lvl = e[1]; // [RL2]
      mctu_pkg::SEL_EXT_C:   lvl = e[2]; // [RL3]
      mctu_pkg::SEL_EXT_D:   lvl = e[3]; // [RL4]
      default:               lvl = 1'b0;
    endcase
    return lvl;
  endfunction : src_level

  // Edge pick from the count edge select field
  function automatic logic edge_pick(input logic [1:0] es,
                                     input logic cur,
                                     input logic prv);
    logic rise;
    logic fall;
    rise = cur && !prv;
    fall = !cur && prv;
    if (es[mctu_pkg::EDGE_BOTH_BIT]) begin
      return rise || fall;
    end
    return (es == mctu_pkg::EDGE_FALL) ? fall : rise; // [RL11]
  endfunction : edge_pick

  // ****************************************************
  // Channels
  // ****************************************************
  logic [NCH-1:0] up;
  logic [NCH-1:0] dn;
  logic [NCH-1:0] phase_on;

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    // Phase inputs: A/B pair for channels 1 and 5, C/D for 2 and 4
    localparam bit HAS_PH = (c == 1) || (c == 2) || (c == 4) || (c == 5);
    localparam int PA     = ((c == 2) || (c == 4)) ? 2 : 0;
    localparam bit HAS_CD = (c == 0) || (c == 3);
    localparam int PREV   = (c == 0) ? NCH - 1 : c - 1;

    wire logic [3:0] sel;
    wire logic       cur;
    wire logic       prv;
    wire logic       tick;
    wire logic       ph_move;
    wire logic       ph_fwd;

    assign sel  = cfg[c].clk_sel;
    assign cur  = src_level(sel, pre, ext_q);
    assign prv  = src_level(sel, pre_q, ext_qq);
    // Undivided and cascade sources bypass the edge select
    assign tick = (sel == mctu_pkg::SEL_DIV1) ? 1'b1 : // [RL12]
                  (sel == mctu_pkg::SEL_CASCADE) ?
                    (irq[PREV].ovf || irq[PREV].udf) : // [RL12]
                  edge_pick(cfg[c].count_edge_sel, cur, prv); // [RL11]

    // Quadrature x4: one phase changes per count; both at once is lost
    assign ph_move = (ext_q[PA] ^ ext_qq[PA]) ^
                     (ext_q[PA+1] ^ ext_qq[PA+1]);
    assign ph_fwd  = ext_q[PA] ^ ext_qq[PA+1];
    assign phase_on[c] = HAS_PH && cfg[c].phase_mode;
    assign up[c] = phase_on[c] ? (ph_move && ph_fwd) : tick; // [RL1] [RL3]
    assign dn[c] = phase_on[c] && ph_move && !ph_fwd; // [RL2] [RL4]

    mctu_chan #(
      .CW      (CW),
      .HAS_CD  (HAS_CD),
      .HAS_UDF (!HAS_CD),
      .HAS_PAT (c < 4)
    ) u_chan (
      .clk             (clk),
      .reset           (reset),
      .up              (up[c]),
      .dn              (dn[c]),
      .role            (cfg[c].role),
      .gr_wr_en        (gr_wr_en[c]),
      .gr_wr_data      (gr_wr_data),
      .pin_in          (capcmp_in[c]),
      .channel_counter (channel_counter[c]),
      .pin_out         (capcmp_out[c]),
      .pin_oe          (capcmp_oe[c]),
      .irq             (irq[c]),
      .trig            (trig[c])
    );
  end

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Channel 0 has no phase mode, so its phase bit is left out here
  sequence s_ch0_ext_rise;
    cfg[0].clk_sel == mctu_pkg::SEL_EXT_A &&
    cfg[0].count_edge_sel == mctu_pkg::EDGE_RISE && ext_q[0] && !ext_qq[0];
  endsequence

  sequence s_ch1_ext_fall;
    cfg[1].clk_sel == mctu_pkg::SEL_EXT_B && !cfg[1].phase_mode &&
    cfg[1].count_edge_sel == mctu_pkg::EDGE_FALL && !ext_q[1] && ext_qq[1];
  endsequence

  a_ext_a_rise: assert property ( // [RL1] [RL11]
    s_ch0_ext_rise |=> channel_counter[0] == $past(channel_counter[0]) + 16'h1)
    else $error("channel 0 missed rising edge of input A");

  a_ext_b_fall: assert property ( // [RL2] [RL11]
    s_ch1_ext_fall |=> channel_counter[1] == $past(channel_counter[1]) + 16'h1)
    else $error("channel 1 missed falling edge of input B");

  a_phase_c_down: assert property ( // [RL3]
    (phase_on[2] && ext_q[2] && !ext_qq[2] && ext_q[3] && ext_qq[3])
    |=> channel_counter[2] == $past(channel_counter[2]) - 16'h1)
    else $error("channel 2 phase count did not go down");

  a_phase_d_down: assert property ( // [RL4]
    (phase_on[4] && ext_q[3] && !ext_qq[3] && !ext_q[2] && !ext_qq[2])
    |=> channel_counter[4] == $past(channel_counter[4]) - 16'h1)
    else $error("channel 4 phase count did not go down");

  a_capture_event: assert property ( // [RL5] [RL6]
    (cfg[0].role[2] == mctu_pkg::ROLE_CAP && $rose(capcmp_in[0][2]))
    |=> irq[0].cm_c && trig[0].xfer_req && !trig[0].conv_start)
    else $error("capture on channel 0 pin C gave no event");

  a_no_cd_pins: assert property ( // [RL6]
    capcmp_oe[1][3:2] == 2'h0 && capcmp_oe[2][3:2] == 2'h0 &&
    capcmp_oe[4][3:2] == 2'h0 && capcmp_oe[5][3:2] == 2'h0)
    else $error("C/D pin driven on a channel without it");

  a_ch0_no_udf: assert property ( // [RL7]
    !irq[0].udf && !irq[3].udf)
    else $error("underflow event on channel 0 or 3");

  a_ch3_overflow: assert property ( // [RL8]
    (up[3] && channel_counter[3] == 16'hffff)
    |=> irq[3].ovf && channel_counter[3] == 16'h0)
    else $error("channel 3 overflow not flagged");

  a_ch2_underflow: assert property ( // [RL9]
    (dn[2] && channel_counter[2] == 16'h0)
    |=> irq[2].udf ##1 !irq[2].udf)
    else $error("channel 2 underflow not a single pulse");

  a_no_pat_hi: assert property ( // [RL10]
    !trig[4].pat_a && !trig[4].pat_b && !trig[5].pat_a && !trig[5].pat_b)
    else $error("pattern trigger from channel 4 or 5");

  a_div1_count: assert property ( // [RL12]
    (cfg[0].clk_sel == mctu_pkg::SEL_DIV1)
    |=> channel_counter[0] == $past(channel_counter[0]) + 16'h1)
    else $error("undivided source did not count every cycle");

  // Five samples: the oldest of the four counted cycles needs the setup too
  a_both_edges: assert property ( // [RL11]
    (cfg[0].clk_sel == mctu_pkg::SEL_DIV4 &&
     cfg[0].count_edge_sel == 2'h2)[*5]
    |-> channel_counter[0] - $past(channel_counter[0], 4) == 16'h2)
    else $error("both-edge count at quarter rate wrong");

endmodule : mctu_top

/* bench/mctu_src.sv */
// Behavioural pulse source and quadrature encoder on the count inputs
`timescale 1ns/1ps
module mctu_src (
  input  wire logic clk,
  output logic      a,
  output logic      b,
  output logic      c,
  output logic      d
);
  logic [1:0] ph;
  initial {a, b, c, d} = 4'h0;
  // ****************************************
  // Pulse trains, same waveform on all four
  // ****************************************
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      {a, b, c, d} <= 4'hf;
      repeat (2) @(posedge clk);
      {a, b, c, d} <= 4'h0;
      @(posedge clk);
    end
  endtask : pulses
  // ****************************************
  // Quadrature: A leads B, D leads C
  // ****************************************
  // Lines rest low between frames, as a stopped encoder would
  task automatic quad(input int n);
    repeat (n) for (int s = 0; s < 4; s++) begin
      repeat (2) @(posedge clk);
      ph = (s == 0) ? 2'h2 : (s == 1) ? 2'h3 : (s == 2) ? 2'h1 : 2'h0;
      {a, b, c, d} <= {ph, ph[0], ph[1]};
    end
  endtask : quad
endmodule : mctu_src

/* bench/tb_mctu_top.sv */
// Self-checking testbench for the six-channel timer
`timescale 1ns/1ps
module tb_mctu_top;
  typedef struct packed {
    logic [2:0] ch;
    logic [9:0] ev;
  } mctu_note_t;
  logic                          clk = 1'b0;
  logic                          reset = 1'b1;
  logic                          ea, eb, ec, ed;
  mctu_pkg::mctu_cfg_t [5:0]     cfg;
  logic [5:0][3:0]               gr_wr_en;
  logic [15:0]                   gr_wr_data;
  logic [5:0][3:0]               capcmp_in;
  logic [5:0][15:0]              channel_counter;
  logic [5:0][3:0]               capcmp_out;
  logic [5:0][3:0]               capcmp_oe;
  mctu_pkg::mctu_irq_t [5:0]     irq;
  mctu_pkg::mctu_trig_t [5:0]    trig;
  mctu_note_t                    notes[$];
  mctu_note_t                    nt;
  mctu_note_t                    sn;
  int                            err_count = 0;
  int                            num_checks = 0;
  int                            n;
  int                            i;
  initial forever #2.5 clk = ~clk;
  mctu_src u_src (.clk(clk), .a(ea), .b(eb), .c(ec), .d(ed));
  mctu_top u_dut (
    .clk(clk), .reset(reset), .ext_count_in_a(ea), .ext_count_in_b(eb),
    .ext_count_in_c(ec), .ext_count_in_d(ed), .cfg(cfg),
    .gr_wr_en(gr_wr_en), .gr_wr_data(gr_wr_data), .capcmp_in(capcmp_in),
    .channel_counter(channel_counter), .capcmp_out(capcmp_out),
    .capcmp_oe(capcmp_oe), .irq(irq), .trig(trig)
  );
  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // Events are sampled mid-cycle, away from the launching edge
  always @(negedge clk) begin
    if (!reset) for (int c = 0; c < 6; c++) begin
      if ({irq[c], trig[c]} !== 10'h0) begin
        nt = (notes.size() > 0) ? notes.pop_front() : '0;
        sn = '{ch: c[2:0], ev: {irq[c], trig[c]}};
        check("event", sn, nt);
      end
    end
  end
  // ****************************************
  // Stimulus helpers
  // ****************************************
  task automatic note(input int c, input logic [9:0] ev);
    notes.push_back('{ch: c[2:0], ev: ev});
  endtask : note
  task automatic setc(input int c, input logic [3:0] s, input logic [1:0] e,
                      input logic p, input logic [7:0] r);
    cfg[c] <= '{clk_sel: s, count_edge_sel: e, phase_mode: p, role: r};
  endtask : setc
  task automatic do_reset;
    @(posedge clk);
    reset <= 1'b1;
    for (int c = 0; c < 6; c++) setc(c, 4'hc, 2'h0, 1'b0, 8'h00);
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
  endtask : do_reset
  task automatic wr_all(input int r, input logic [15:0] v);
    @(posedge clk);
    for (int c = 0; c < 6; c++) gr_wr_en[c][r] <= 1'b1;
    gr_wr_data <= v;
    @(posedge clk);
    gr_wr_en <= '0;
  endtask : wr_all
  task automatic pins(input logic [3:0] e03, input logic [3:0] e);
    repeat (3) @(posedge clk);
    for (int c = 0; c < 6; c++)
      check("pins", capcmp_out[c], (c % 3 == 0) ? e03 : e);
  endtask : pins
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    cfg = '0;
    gr_wr_en = '0;
    gr_wr_data = 16'h0000;
    capcmp_in = '0;
    void'($urandom(32'h57e9));
    n = 3 + ($urandom % 5);
    do_reset;
    for (int c = 0; c < 6; c++)
      check("cnt", channel_counter[c], 16'h0000);
    // Edge select on each external input; cascade with no source stays put
    setc(0, mctu_pkg::SEL_EXT_A, 2'h0, 1'b0, 8'h00);
    setc(1, mctu_pkg::SEL_EXT_B, 2'h1, 1'b0, 8'h00);
    setc(2, mctu_pkg::SEL_EXT_C, 2'h2, 1'b0, 8'h00);
    setc(3, mctu_pkg::SEL_EXT_D, 2'h3, 1'b0, 8'h00);
    setc(5, mctu_pkg::SEL_CASCADE, 2'h0, 1'b0, 8'h00);
    u_src.pulses(n);
    repeat (4) @(posedge clk);
    check("cnt", channel_counter[0], 16'(n));
    check("cnt", channel_counter[1], 16'(n));
    check("cnt", channel_counter[2], 16'(2 * n));
    check("cnt", channel_counter[3], 16'(2 * n));
    check("cnt", channel_counter[4], 16'h0000);
    check("cnt", channel_counter[5], 16'h0000);
    // Quarter rate on both edges: 20 cycles give exactly 10 counts
    setc(0, mctu_pkg::SEL_DIV4, 2'h2, 1'b0, 8'h00);
    repeat (20) @(posedge clk);
    setc(0, 4'hc, 2'h0, 1'b0, 8'h00);
    repeat (2) @(posedge clk);
    check("cnt", channel_counter[0], 16'(n + 10));
    // Phase counting, ch1/5 up, ch2/4 down through zero
    do_reset;
    setc(0, mctu_pkg::SEL_EXT_A, 2'h0, 1'b1, 8'h00);
    setc(3, mctu_pkg::SEL_EXT_D, 2'h2, 1'b1, 8'h00);
    for (int c = 1; c < 6; c += 4)
      setc(c, mctu_pkg::SEL_EXT_A, 2'h1, 1'b1, 8'h00);
    for (int c = 2; c < 5; c += 2)
      setc(c, mctu_pkg::SEL_EXT_C, 2'h2, 1'b1, 8'h00);
    note(2, 10'b000001_0000);
    note(4, 10'b000001_0000);
    u_src.quad(n);
    repeat (4) @(posedge clk);
    check("cnt", channel_counter[0], 16'(n));
    check("cnt", channel_counter[3], 16'(2 * n));
    for (int c = 1; c < 6; c += 4)
      check("cnt", channel_counter[c], 16'(4 * n));
    for (int c = 2; c < 5; c += 2)
      check("cnt", channel_counter[c], 16'(-4 * n));
    // Compare and PWM roles on every channel, capture only on channels 0 and 3
    do_reset;
    for (int c = 0; c < 6; c++) setc(c, 4'hc, 2'h0, 1'b0, 8'h9e);
    wr_all(0, 16'h000a);
    wr_all(3, 16'h000f);
    pins(4'b0010, 4'b0010);
    for (int c = 0; c < 6; c++)
      check("oe", capcmp_oe[c], (c % 3 == 0) ? 4'hb : 4'h3);
    // Same-cycle events are popped in channel order, so note them that way
    for (int c = 0; c < 6; c++) note(c, (c < 4) ? 10'h20e : 10'h20c);
    note(0, 10'b000100_1000);
    note(3, 10'b000100_1000);
    // Undivided source, edge field set to fall but ignored
    for (int c = 0; c < 6; c++) setc(c, mctu_pkg::SEL_DIV1, 2'h1, 1'b0, 8'h9e);
    repeat (40) @(posedge clk);
    for (int c = 0; c < 6; c++) setc(c, 4'hc, 2'h0, 1'b0, 8'h9e);
    pins(4'b1011, 4'b0011);
    wr_all(1, 16'h0005);
    pins(4'b1001, 4'b0001);
    note(0, 10'b001000_1000);
    note(3, 10'b001000_1000);
    @(posedge clk);
    for (int c = 0; c < 6; c++) capcmp_in[c][2] <= 1'b1;
    repeat (2) @(posedge clk);
    capcmp_in <= '0;
    // Overflow of ch0 feeds the cascaded ch1
    do_reset;
    setc(0, mctu_pkg::SEL_DIV1, 2'h0, 1'b0, 8'h00);
    setc(1, mctu_pkg::SEL_CASCADE, 2'h0, 1'b0, 8'h00);
    setc(3, mctu_pkg::SEL_DIV1, 2'h0, 1'b0, 8'h00);
    note(0, 10'b000010_0000);
    note(3, 10'b000010_0000);
    for (i = 0; i < 70000 && channel_counter[1] !== 16'h0001; i++)
      @(posedge clk);
    if (i >= 70000) begin
      err_count++;
    end else begin
      check("cnt", channel_counter[1], 16'h0001);
      repeat (4) @(posedge clk);
      check("pending", 16'(notes.size()), 16'h0000);
    end
    summarize;
  end
endmodule : tb_mctu_top
